// File: gshr_pkg.sv
// package: register map, command codes, defaults and carrier types for the holding-register bank
package gshr_pkg;

  // holding-register offsets (register index on the serial protocol)
  localparam logic [15:0] ADDR_CAL_CMD      = 16'h0000;
  localparam logic [15:0] ADDR_CAL_REF      = 16'h0002;
  localparam logic [15:0] ADDR_OVERRIDE     = 16'h0003;
  localparam logic [15:0] ADDR_ABC_HOURS    = 16'h0004;
  localparam logic [15:0] ADDR_RSVD         = 16'h0005;
  localparam logic [15:0] ADDR_MEAS_PERIOD  = 16'h000B;
  localparam logic [15:0] ADDR_SAMPLES      = 16'h000C;
  localparam logic [15:0] ADDR_ABC_PERIOD   = 16'h000D;
  localparam logic [15:0] ADDR_ERR_CLEAR    = 16'h000E;
  localparam logic [15:0] ADDR_ABC_REF      = 16'h000F;
  localparam logic [15:0] ADDR_FILTER       = 16'h0010;
  localparam logic [15:0] ADDR_RESTART      = 16'h0011;
  localparam logic [15:0] ADDR_METER        = 16'h0012;

  // calibration command codes
  localparam logic [15:0] CMD_RESTORE       = 16'h7C02;
  localparam logic [15:0] CMD_FORCED_ABC    = 16'h7C03;
  localparam logic [15:0] CMD_TARGET        = 16'h7C05;
  localparam logic [15:0] CMD_BACKGROUND    = 16'h7C06;
  localparam logic [15:0] CMD_ZERO          = 16'h7C07;

  // values after reset and field limits
  localparam logic [15:0] CMD_RST           = 16'h0000;
  localparam logic [15:0] CAL_REF_RST       = 16'h0000;
  localparam logic [15:0] ABC_REF_RST       = 16'h0000;
  localparam logic [15:0] OVERRIDE_NONE     = 16'h7FFF;
  localparam logic [15:0] PERIOD_RST        = 16'h0010;
  localparam logic [15:0] PERIOD_MIN        = 16'h0002;
  localparam logic [15:0] PERIOD_MAX        = 16'hFFFE;
  localparam logic [15:0] SAMPLES_RST       = 16'h0008;
  localparam logic [15:0] SAMPLES_MIN       = 16'h0001;
  localparam logic [15:0] SAMPLES_MAX       = 16'h0400;
  localparam logic [15:0] SAMPLES_INT_MIN   = 16'h0002;
  localparam logic [15:0] ABC_PERIOD_RST    = 16'h02D0;
  localparam logic [15:0] ABC_PERIOD_OFF_LO = 16'h0000;
  localparam logic [15:0] ABC_PERIOD_OFF_HI = 16'hFFFF;
  localparam logic [15:0] FILTER_RST        = 16'h0002;
  localparam logic [15:0] FILTER_MIN        = 16'h0002;
  localparam logic [15:0] FILTER_MAX        = 16'h000A;
  localparam logic [15:0] RESTART_KEY       = 16'h00FF;
  localparam logic [1:0]  METER_RST         = 2'b00;
  localparam int          METER_HEATER_BIT  = 0;
  localparam int          METER_ABC_BIT     = 1;

  // timing: one second of the measurement scheduler
  localparam int          CLK_MHZ           = 100;
  localparam int          SECOND_MS         = 1000;
  localparam int          SECOND_CYCLES     = SECOND_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    CAL_NONE,
    CAL_RESTORE,
    CAL_ABC,
    CAL_TARGET,
    CAL_BACKGROUND,
    CAL_ZERO
  } gshr_cal_kind_t;

  typedef enum logic [1:0] {
    MS_LAUNCH,
    MS_BUSY,
    MS_WAIT
  } gshr_meas_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } gshr_hr_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } gshr_hr_rsp_t;

  typedef struct packed {
    gshr_cal_kind_t kind;
    logic [15:0]    reference;
  } gshr_cal_cmd_t;

endpackage : gshr_pkg

// File: gshr_bank.sv
// gas-sensor holding-register bank: calibration commands, configuration and measurement scheduling
// Notes on behaviour
// - restore command reloads factory calibration parameters
// - forced ABC needs valid data and enable
// - background calibration references the ABC target
// - zero calibration assumes zero ppm gas
// - target calibration references the calibration target
// - command applied at next measurement completion
// - override below 32767 forces both concentration results
// - report hours since last baseline calibration
// - period 2..65534 seconds, odd rounds up
// - period and sample count act after restart
// - sample count 1..1024, default eight
// - odd samples round down, minimum two internally
// - overlong sampling stretches the measurement period
// - ABC period 1..65534 hours, default 720
// - ABC enabled for valid period, bit1 clear
// - ABC disabled for 0, 65535 or bit1
// - any error-clear write clears error flags word
// - ABC target feeds background and automatic calibrations
// - static filter strength limited to 2..10
// - writing 0xFF to restart register restarts device
// - meter bits: heater off, ABC off, default 0
`timescale 1ns/1ps
`default_nettype none

module gshr_bank
  import gshr_pkg::*;
#(
  parameter int SECOND_CYCLES_P = SECOND_CYCLES
) (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire gshr_hr_req_t  hr_req,
  output gshr_hr_rsp_t       hr_rsp,
  input  wire logic          meas_done,
  input  wire logic          hour_tick,
  input  wire logic          abc_data_valid,
  output logic               meas_start,
  output logic               cal_start,
  output gshr_cal_cmd_t      cal_cmd,
  output logic               conc_override_en,
  output logic [15:0]        conc_override_value,
  output logic               error_clear,
  output logic               restart_pulse,
  output logic               heater_en,
  output logic               abc_en,
  output logic [15:0]        filter_strength,
  output logic [15:0]        active_period,
  output logic [15:0]        active_samples
);

  if (SECOND_CYCLES_P < 2) begin : g_bad_second
    $error("SECOND_CYCLES_P must be at least 2");
  end

  // stored registers
  logic [15:0]       cal_command;
  logic [15:0]       cal_reference_value;
  logic [15:0]       concentration_override_value;
  logic [15:0]       hours_since_auto_calibration;
  logic [15:0]       measurement_interval_seconds;
  logic [15:0]       samples_per_measurement;
  logic [15:0]       auto_calibration_interval;
  logic [15:0]       auto_calibration_reference;
  logic [15:0]       static_filter_strength;
  logic [1:0]        meter_function_enables;

  // calibration bookkeeping
  gshr_cal_kind_t    pending_kind;
  logic              pending_valid;

  // scheduler
  gshr_meas_state_t  meas_state;
  gshr_meas_state_t  next_meas_state;
  logic [31:0]       cycle_cnt;
  logic [15:0]       sec_cnt;

  // access decode
  wire logic         wr_en        = hr_req.wr;
  wire logic         rd_en        = hr_req.rd & ~hr_req.wr;
  wire logic [15:0]  wd           = hr_req.wdata;
  wire logic         hit_cmd      = (hr_req.addr == ADDR_CAL_CMD);
  wire logic         hit_cal_ref  = (hr_req.addr == ADDR_CAL_REF);
  wire logic         hit_override = (hr_req.addr == ADDR_OVERRIDE);
  wire logic         hit_hours    = (hr_req.addr == ADDR_ABC_HOURS);
  wire logic         hit_rsvd     = (hr_req.addr == ADDR_RSVD);
  wire logic         hit_period   = (hr_req.addr == ADDR_MEAS_PERIOD);
  wire logic         hit_samples  = (hr_req.addr == ADDR_SAMPLES);
  wire logic         hit_abc_per  = (hr_req.addr == ADDR_ABC_PERIOD);
  wire logic         hit_err_clr  = (hr_req.addr == ADDR_ERR_CLEAR);
  wire logic         hit_abc_ref  = (hr_req.addr == ADDR_ABC_REF);
  wire logic         hit_filter   = (hr_req.addr == ADDR_FILTER);
  wire logic         hit_restart  = (hr_req.addr == ADDR_RESTART);
  wire logic         hit_meter    = (hr_req.addr == ADDR_METER);
  wire logic         hit_any      = hit_cmd | hit_cal_ref | hit_override | hit_hours | hit_rsvd | hit_period
                                    | hit_samples | hit_abc_per | hit_err_clr | hit_abc_ref | hit_filter
                                    | hit_restart | hit_meter;
  // the elapsed-hours counter is not writable
  wire logic         wr_refused   = wr_en & (~hit_any | hit_hours);

  wire logic         wr_cmd       = wr_en & hit_cmd;
  wire logic         wr_restart   = wr_en & hit_restart & (wd == RESTART_KEY);

  // write-side value shaping
  wire logic [15:0]  period_clamp = (wd < PERIOD_MIN) ? PERIOD_MIN : ((wd > PERIOD_MAX) ? PERIOD_MAX : wd);
  wire logic [15:0]  period_even  = period_clamp + {15'h0000, period_clamp[0]};
  wire logic [15:0]  samples_clmp = (wd < SAMPLES_MIN) ? SAMPLES_MIN
                                    : ((wd > SAMPLES_MAX) ? SAMPLES_MAX : wd);
  wire logic [15:0]  filter_clamp = (wd < FILTER_MIN) ? FILTER_MIN
                                    : ((wd > FILTER_MAX) ? FILTER_MAX : wd);

  // internal sample count: even, never below two
  wire logic [15:0]  samples_even = {samples_per_measurement[15:1], 1'b0};
  wire logic [15:0]  samples_int  = (samples_even < SAMPLES_INT_MIN) ? SAMPLES_INT_MIN : samples_even;

  // automatic baseline calibration enable
  wire logic         abc_per_ok   = (auto_calibration_interval != ABC_PERIOD_OFF_LO)
                                    & (auto_calibration_interval != ABC_PERIOD_OFF_HI);
  wire logic         abc_enable   = abc_per_ok & ~meter_function_enables[METER_ABC_BIT];
  wire logic         abc_due      = abc_enable & (hours_since_auto_calibration >= auto_calibration_interval);

  // command decode
  gshr_cal_kind_t    cmd_kind;
  always_comb begin
    case (wd)
      CMD_RESTORE:    cmd_kind = CAL_RESTORE;
      CMD_FORCED_ABC: cmd_kind = CAL_ABC;
      CMD_TARGET:     cmd_kind = CAL_TARGET;
      CMD_BACKGROUND: cmd_kind = CAL_BACKGROUND;
      CMD_ZERO:       cmd_kind = CAL_ZERO;
      default:        cmd_kind = CAL_NONE;
    endcase
  end

  // what fires at the end of the current measurement; a command wins over a due automatic run
  gshr_cal_kind_t    fire_kind;
  logic [15:0]       fire_ref;
  always_comb begin
    fire_kind = CAL_NONE;
    if (pending_valid) begin
      // forced run is dropped unless baseline data is held and the function is on
      if (pending_kind == CAL_ABC) begin
        fire_kind = (abc_data_valid & abc_enable) ? CAL_ABC : CAL_NONE;
      end else begin
        fire_kind = pending_kind;
      end
    end else if (abc_due & abc_data_valid) begin
      fire_kind = CAL_ABC;
    end
  end

  always_comb begin
    case (fire_kind)
      CAL_TARGET:     fire_ref = cal_reference_value;
      CAL_BACKGROUND: fire_ref = auto_calibration_reference;
      CAL_ABC:        fire_ref = auto_calibration_reference;
      CAL_ZERO:       fire_ref = 16'h0000;
      default:        fire_ref = 16'h0000;
    endcase
  end

  wire logic         apply_now    = meas_done & (meas_state == MS_BUSY);
  wire logic         fire         = apply_now & (fire_kind != CAL_NONE);
  wire logic         abc_fired    = fire & (fire_kind == CAL_ABC);

  // register writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cal_command                  <= CMD_RST;
      cal_reference_value          <= CAL_REF_RST;
      concentration_override_value <= OVERRIDE_NONE;
      measurement_interval_seconds <= PERIOD_RST;
      samples_per_measurement      <= SAMPLES_RST;
      auto_calibration_interval    <= ABC_PERIOD_RST;
      auto_calibration_reference   <= ABC_REF_RST;
      static_filter_strength       <= FILTER_RST;
      meter_function_enables       <= METER_RST;
    end else if (wr_en) begin
      if (hit_cmd)      cal_command                  <= wd;
      if (hit_cal_ref)  cal_reference_value          <= wd;
      if (hit_override) concentration_override_value <= wd;
      if (hit_period)   measurement_interval_seconds <= period_even;
      if (hit_samples)  samples_per_measurement      <= samples_clmp;
      if (hit_abc_per)  auto_calibration_interval    <= wd;
      if (hit_abc_ref)  auto_calibration_reference   <= wd;
      if (hit_filter)   static_filter_strength       <= filter_clamp;
      if (hit_meter)    meter_function_enables       <= wd[1:0];
    end
  end

  // pending command: a write in the cycle the old one fires keeps the new one
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pending_valid <= 1'b0;
      pending_kind  <= CAL_NONE;
    end else if (wr_restart) begin
      pending_valid <= 1'b0;
      pending_kind  <= CAL_NONE;
    end else if (wr_cmd) begin
      // writing zero (or an unknown code) withdraws whatever was waiting
      pending_valid <= (cmd_kind != CAL_NONE);
      pending_kind  <= cmd_kind;
    end else if (apply_now & pending_valid) begin
      pending_valid <= 1'b0;
      pending_kind  <= CAL_NONE;
    end
  end

  // elapsed hours, saturating; cleared by every baseline calibration that fires
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hours_since_auto_calibration <= 16'h0000;
    end else if (abc_fired) begin
      hours_since_auto_calibration <= 16'h0000;
    end else if (hour_tick && (hours_since_auto_calibration != 16'hFFFF)) begin
      hours_since_auto_calibration <= hours_since_auto_calibration + 16'h0001;
    end
  end

  // calibration request to the measurement core
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cal_start <= 1'b0;
      cal_cmd   <= '{kind: CAL_NONE, reference: 16'h0000};
    end else begin
      cal_start <= fire;
      if (fire) begin
        cal_cmd <= '{kind: fire_kind, reference: fire_ref};
      end
    end
  end

  // configuration in force; stored values only take over at restart
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      active_period  <= PERIOD_RST;
      active_samples <= SAMPLES_RST;
    end else if (wr_restart) begin
      active_period  <= measurement_interval_seconds;
      active_samples <= samples_int;
    end
  end

  // measurement scheduler: a new measurement waits both for the period and for the running one
  always_comb begin
    next_meas_state = meas_state;
    case (meas_state)
      MS_LAUNCH: next_meas_state = MS_BUSY;
      MS_BUSY: begin
        if (meas_done) begin
          next_meas_state = (sec_cnt >= active_period) ? MS_LAUNCH : MS_WAIT;
        end
      end
      MS_WAIT: begin
        if (sec_cnt >= active_period) begin
          next_meas_state = MS_LAUNCH;
        end
      end
      default: next_meas_state = MS_LAUNCH;
    endcase
  end

  wire logic         sec_wrap     = (cycle_cnt == 32'(SECOND_CYCLES_P - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meas_state <= MS_LAUNCH;
      cycle_cnt  <= 32'h0000_0000;
      sec_cnt    <= 16'h0000;
    end else if (wr_restart || meas_state == MS_LAUNCH) begin
      meas_state <= wr_restart ? MS_LAUNCH : next_meas_state;
      cycle_cnt  <= 32'h0000_0000;
      sec_cnt    <= 16'h0000;
    end else begin
      meas_state <= next_meas_state;
      cycle_cnt  <= sec_wrap ? 32'h0000_0000 : cycle_cnt + 32'h0000_0001;
      if (sec_wrap && sec_cnt != 16'hFFFF) begin
        sec_cnt <= sec_cnt + 16'h0001;
      end
    end
  end

  assign meas_start = (meas_state == MS_LAUNCH);

  // one-cycle side effects of writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      error_clear   <= 1'b0;
      restart_pulse <= 1'b0;
    end else begin
      error_clear   <= wr_en & hit_err_clr;
      restart_pulse <= wr_restart;
    end
  end

  // steady outputs from stored registers
  assign conc_override_en    = (concentration_override_value < OVERRIDE_NONE);
  assign conc_override_value = concentration_override_value;
  assign heater_en           = ~meter_function_enables[METER_HEATER_BIT];
  assign abc_en              = abc_enable;
  assign filter_strength     = static_filter_strength;

  // read data; trigger registers and the reserved slot read as zero
  logic [15:0]       rd_value;
  always_comb begin
    rd_value = 16'h0000;
    if (hit_cmd) begin
      rd_value = cal_command;
    end else if (hit_cal_ref) begin
      rd_value = cal_reference_value;
    end else if (hit_override) begin
      rd_value = concentration_override_value;
    end else if (hit_hours) begin
      rd_value = hours_since_auto_calibration;
    end else if (hit_period) begin
      rd_value = measurement_interval_seconds;
    end else if (hit_samples) begin
      rd_value = samples_per_measurement;
    end else if (hit_abc_per) begin
      rd_value = auto_calibration_interval;
    end else if (hit_abc_ref) begin
      rd_value = auto_calibration_reference;
    end else if (hit_filter) begin
      rd_value = static_filter_strength;
    end else if (hit_meter) begin
      rd_value = {14'h0000, meter_function_enables};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hr_rsp <= '{ack: 1'b0, err: 1'b0, rdata: 16'h0000};
    end else begin
      hr_rsp.ack   <= wr_en | rd_en;
      hr_rsp.err   <= wr_refused | (rd_en & ~hit_any);
      hr_rsp.rdata <= (rd_en & hit_any) ? rd_value : 16'h0000;
    end
  end

endmodule : gshr_bank

`default_nettype wire

// File: gshr_meas_model.sv
// measurement engine model: answers each measurement start after a short or a long sampling time
`timescale 1ns/1ps
`default_nettype none

module gshr_meas_model #(
  parameter int FAST = 3,
  parameter int SLOW = 60
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic slow,
  input  wire logic meas_start,
  output logic      meas_done
);
  int left;

  // a new start while sampling restarts the count, since a restart aborts the running measurement
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      left      <= 0;
      meas_done <= 1'b0;
    end else begin
      meas_done <= (left == 1);
      if (meas_start) left <= slow ? SLOW : FAST;
      else if (left > 0) left <= left - 1;
    end
  end
endmodule : gshr_meas_model

`default_nettype wire

// File: gshr_bank_assertions.sv
// concurrent checks on the ports of the holding-register bank
`timescale 1ns/1ps
`default_nettype none

module gshr_bank_assertions
  import gshr_pkg::*;
#(
  parameter int SECOND_CYCLES_P = SECOND_CYCLES
) (
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire gshr_hr_req_t  hr_req,
  input  wire gshr_hr_rsp_t  hr_rsp,
  input  wire logic          meas_done,
  input  wire logic          hour_tick,
  input  wire logic          abc_data_valid,
  input  wire logic          meas_start,
  input  wire logic          cal_start,
  input  wire gshr_cal_cmd_t cal_cmd,
  input  wire logic          conc_override_en,
  input  wire logic [15:0]   conc_override_value,
  input  wire logic          error_clear,
  input  wire logic          restart_pulse,
  input  wire logic          heater_en,
  input  wire logic          abc_en,
  input  wire logic [15:0]   filter_strength,
  input  wire logic [15:0]   active_period,
  input  wire logic [15:0]   active_samples
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  wire logic wr_meter = hr_req.wr && hr_req.addr == ADDR_METER;
  wire logic wr_abcp  = hr_req.wr && hr_req.addr == ADDR_ABC_PERIOD;
  wire logic wr_errc  = hr_req.wr && hr_req.addr == ADDR_ERR_CLEAR;
  wire logic wr_key   = hr_req.wr && hr_req.addr == ADDR_RESTART && hr_req.wdata == RESTART_KEY;

  a_override_flag: assert property (conc_override_en == (conc_override_value < OVERRIDE_NONE))
    else $error("override flag disagrees with override value");
  a_heater_bit: assert property (wr_meter |=> heater_en == !$past(hr_req.wdata[0]))
    else $error("heater enable does not follow meter bit 0");
  a_abc_meter_off: assert property (wr_meter && hr_req.wdata[1] |=> !abc_en)
    else $error("baseline calibration still on after meter bit 1 set");
  a_abc_period_off: assert property (wr_abcp && (hr_req.wdata == 16'h0000 || hr_req.wdata == 16'hFFFF)
    |=> !abc_en)
    else $error("baseline calibration still on with period 0 or 65535");
  a_abc_rise_cause: assert property ($rose(abc_en) |-> $past(wr_meter || wr_abcp))
    else $error("baseline calibration enabled without a config write");
  a_clear_pulse: assert property (wr_errc |=> error_clear)
    else $error("error clear missing after write");
  a_clear_cause: assert property (error_clear |-> $past(wr_errc))
    else $error("error clear without write");
  a_restart_key: assert property (wr_key |=> restart_pulse && meas_start)
    else $error("restart key did not restart");
  a_restart_cause: assert property (restart_pulse |-> $past(wr_key))
    else $error("restart without key write");
  a_cal_after_done: assert property (cal_start |-> $past(meas_done))
    else $error("calibration not tied to a finished measurement");
  a_zero_reference: assert property (cal_start && cal_cmd.kind == CAL_ZERO
    |-> cal_cmd.reference == 16'h0000)
    else $error("zero calibration with nonzero reference");
  a_active_hold: assert property ($changed(active_samples) || $changed(active_period) |-> restart_pulse)
    else $error("active settings changed without restart");
  a_restart_shape: assert property (restart_pulse |-> !active_samples[0]
    && active_samples >= SAMPLES_INT_MIN && !active_period[0] && active_period >= PERIOD_MIN)
    else $error("active settings not even or below minimum");
endmodule : gshr_bank_assertions

bind gshr_bank gshr_bank_assertions #(.SECOND_CYCLES_P(SECOND_CYCLES_P)) i_chk (
  .mclk(mclk), .arst_n(arst_n), .hr_req(hr_req), .hr_rsp(hr_rsp), .meas_done(meas_done),
  .hour_tick(hour_tick), .abc_data_valid(abc_data_valid), .meas_start(meas_start), .cal_start(cal_start),
  .cal_cmd(cal_cmd), .conc_override_en(conc_override_en), .conc_override_value(conc_override_value),
  .error_clear(error_clear), .restart_pulse(restart_pulse), .heater_en(heater_en), .abc_en(abc_en),
  .filter_strength(filter_strength), .active_period(active_period), .active_samples(active_samples)
);

`default_nettype wire

// File: gas_sensor_holding_register_bank_test.sv
// testbench: register port scenarios for the holding-register bank with a measurement model
`timescale 1ns/1ps
`default_nettype none

module gas_sensor_holding_register_bank_test;
  import gshr_pkg::*;
  logic          mclk, arst_n, hour_tick, abc_data_valid, slow, meas_done, meas_start, cal_start;
  logic          conc_override_en, error_clear, restart_pulse, heater_en, abc_en;
  logic [15:0]   conc_override_value, filter_strength, active_period, active_samples, rdata;
  gshr_hr_req_t  hr_req;
  gshr_hr_rsp_t  hr_rsp;
  gshr_cal_cmd_t cal_cmd;
  int            err_total, num_checks;

  gshr_bank #(.SECOND_CYCLES_P(10)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .hr_req(hr_req), .hr_rsp(hr_rsp), .meas_done(meas_done),
    .hour_tick(hour_tick), .abc_data_valid(abc_data_valid), .meas_start(meas_start), .cal_start(cal_start),
    .cal_cmd(cal_cmd), .conc_override_en(conc_override_en), .conc_override_value(conc_override_value),
    .error_clear(error_clear), .restart_pulse(restart_pulse), .heater_en(heater_en), .abc_en(abc_en),
    .filter_strength(filter_strength), .active_period(active_period), .active_samples(active_samples));
  gshr_meas_model i_meas (.mclk(mclk), .arst_n(arst_n), .slow(slow), .meas_start(meas_start), .meas_done(meas_done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // one request cycle, then the answer is looked at in the single cycle it stands
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e);
    @(negedge mclk);
    hr_req = '{w, !w, a, d};
    @(negedge mclk);
    chk("ack", 16'h0001, {15'h0, hr_rsp.ack});
    chk("err", {15'h0, e}, {15'h0, hr_rsp.err});
    rdata = hr_rsp.rdata;
    hr_req = '0;
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 1'b0);
    chk($sformatf("reg %0h", a), exp, rdata);
  endtask : rd

  task automatic cal_wait(input logic want);
    for (int i = 0; i < 400 && cal_start !== 1'b1; i++) @(negedge mclk);
    chk("cal_start", {15'h0, want}, {15'h0, cal_start});
    if (want && cal_start !== 1'b1) test_done();
  endtask : cal_wait

  task automatic t_reset;
    chk("override_en", 16'h0000, {15'h0, conc_override_en});
    chk("heater_en", 16'h0001, {15'h0, heater_en});
    chk("active_samples", SAMPLES_RST, active_samples);
    rd(ADDR_OVERRIDE, 16'h7FFF);
    rd(ADDR_SAMPLES, 16'h0008);
    rd(ADDR_ABC_PERIOD, 16'h02D0);
    rd(ADDR_METER, 16'h0000);
  endtask : t_reset

  task automatic t_config;
    logic [15:0] per[4] = '{16'h0000, 16'hFFFF, 16'h0001, 16'hFFFE};
    wr(ADDR_MEAS_PERIOD, 16'h0001);
    rd(ADDR_MEAS_PERIOD, 16'h0002);
    wr(ADDR_MEAS_PERIOD, 16'h0005);
    rd(ADDR_MEAS_PERIOD, 16'h0006);
    wr(ADDR_FILTER, 16'h000B);
    chk("filter", 16'h000A, filter_strength);
    bus(1'b0, 16'h0006, 16'h0000, 1'b1);
    rd(ADDR_RSVD, 16'h0000);
    wr(ADDR_OVERRIDE, 16'h0064);
    chk("override_en", 16'h0001, {15'h0, conc_override_en});
    chk("override_value", 16'h0064, conc_override_value);
    wr(ADDR_OVERRIDE, OVERRIDE_NONE);
    chk("override_off", 16'h0000, {15'h0, conc_override_en});
    wr(ADDR_METER, 16'h0003);
    chk("heater_off", 16'h0000, {15'h0, heater_en});
    chk("abc_meter_off", 16'h0000, {15'h0, abc_en});
    wr(ADDR_METER, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_ABC_PERIOD, per[k]);
      chk("abc_en", {15'h0, k[1]}, {15'h0, abc_en});
    end
    wr(ADDR_ABC_PERIOD, ABC_PERIOD_RST);
    wr(ADDR_ERR_CLEAR, 16'h1234);
    chk("error_clear", 16'h0001, {15'h0, error_clear});
  endtask : t_config

  task automatic t_cal;
    gshr_cal_kind_t kinds[5] = '{CAL_RESTORE, CAL_ABC, CAL_TARGET, CAL_BACKGROUND, CAL_ZERO};
    logic [15:0]    codes[5] = '{CMD_RESTORE, CMD_FORCED_ABC, CMD_TARGET, CMD_BACKGROUND, CMD_ZERO};
    logic [15:0]    refs[5]  = '{16'h0000, 16'h0567, 16'h1234, 16'h0567, 16'h0000};
    wr(ADDR_CAL_REF, 16'h1234);
    wr(ADDR_ABC_REF, 16'h0567);
    for (int k = 0; k < 5; k++) begin
      slow = k[0];
      wr(ADDR_CAL_CMD, 16'h0000);
      wr(ADDR_CAL_CMD, codes[k]);
      cal_wait(1'b1);
      chk("kind", {13'h0, kinds[k]}, {13'h0, cal_cmd.kind});
      chk("reference", refs[k], cal_cmd.reference);
    end
    abc_data_valid = 1'b0;
    wr(ADDR_CAL_CMD, 16'h0000);
    wr(ADDR_CAL_CMD, CMD_FORCED_ABC);
    cal_wait(1'b0);
    abc_data_valid = 1'b1;
    wr(ADDR_METER, 16'h0002);
    wr(ADDR_CAL_CMD, 16'h0000);
    wr(ADDR_CAL_CMD, CMD_FORCED_ABC);
    cal_wait(1'b0);
    wr(ADDR_METER, 16'h0000);
    wr(ADDR_CAL_CMD, 16'h0000);
  endtask : t_cal

  task automatic t_hours;
    repeat (3) begin
      @(negedge mclk);
      hour_tick = 1'b1;
      @(negedge mclk);
      hour_tick = 1'b0;
    end
    rd(ADDR_ABC_HOURS, 16'h0003);
    bus(1'b1, ADDR_ABC_HOURS, 16'h0000, 1'b1);
    wr(ADDR_ABC_PERIOD, 16'h0003);
    cal_wait(1'b1);
    chk("auto_kind", {13'h0, CAL_ABC}, {13'h0, cal_cmd.kind});
    chk("auto_ref", 16'h0567, cal_cmd.reference);
    rd(ADDR_ABC_HOURS, 16'h0000);
    wr(ADDR_ABC_PERIOD, ABC_PERIOD_RST);
  endtask : t_hours

  task automatic t_restart;
    int n;
    wr(ADDR_SAMPLES, 16'h0005);
    wr(ADDR_MEAS_PERIOD, 16'h0003);
    chk("active_samples", 16'h0008, active_samples);
    chk("active_period", PERIOD_RST, active_period);
    wr(ADDR_RESTART, 16'h00FE);
    chk("no_restart", 16'h0000, {15'h0, restart_pulse});
    wr(ADDR_RESTART, RESTART_KEY);
    chk("restart", 16'h0001, {15'h0, restart_pulse});
    chk("active_samples", 16'h0004, active_samples);
    chk("active_period", 16'h0004, active_period);
    wr(ADDR_SAMPLES, 16'h07D0);
    rd(ADDR_SAMPLES, SAMPLES_MAX);
    wr(ADDR_SAMPLES, 16'h0001);
    rd(ADDR_SAMPLES, 16'h0001);
    slow = 1'b1;
    wr(ADDR_RESTART, RESTART_KEY);
    chk("active_min", SAMPLES_INT_MIN, active_samples);
    // period is now 4 s (40 cycles) but sampling takes 60: the next start must wait for it
    @(negedge mclk);
    for (n = 0; n < 100 && !meas_start; n++) @(negedge mclk);
    chk("stretch", 16'h0001, {15'h0, n > 40 && n < 100});
  endtask : t_restart

  initial begin
    arst_n = 1'b0;
    hr_req = '0;
    hour_tick = 1'b0;
    abc_data_valid = 1'b1;
    slow = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    t_reset();
    t_config();
    t_cal();
    t_hours();
    t_restart();
    test_done();
  end
endmodule : gas_sensor_holding_register_bank_test

`default_nettype wire
